/* File: hdl/fwec_pkg.sv */
// constants shared by the flash write and erase sequencer
`default_nettype none
package fwec_pkg;
	// register byte offsets on the bus
	localparam logic [7:0] OFS_STORE_CTRL = 8'h00;
	localparam logic [7:0] OFS_FLASH_SCALE = 8'h04;
	localparam logic [7:0] OFS_BANK = 8'h08;
	localparam logic [7:0] OFS_CACHE_CTRL = 8'h0C;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	// field positions
	localparam int SWE_BIT = 0;
	localparam int SEE_BIT = 1;
	localparam int SSEL_BIT = 2;
	localparam int UFE_BIT = 0;
	localparam int BLK_BIT = 0;
	localparam int BUSY_BIT = 0;
	localparam int BANK_LSB = 4;
	localparam int BANK_MSB = 5;
	localparam int PAGE_LSB = 10;
	localparam int SCR_PAGE_LSB = 7;
	// reset values
	localparam logic [2:0] STORE_CTRL_RST = 3'h0;
	localparam logic [1:0] BANK_RST = 2'h0;
	// address map
	localparam logic [17:0] SCR_BASE = 18'h20000;
	localparam logic [7:0] RSV_PAGE = 8'h7F;
	localparam logic [15:0] SCR_BOTH_ADDR = 16'h0400;
	localparam logic [1:0] LAST_LANE = 2'h3;
	localparam logic [7:0] ERASED_BYTE = 8'hFF;
	// timing
	localparam int CLK_MHZ = 40;
	localparam int ERASE_TIME_US = 10000;
	localparam int PROG_TIME_US = 40;
	localparam int ERASE_CYC = ERASE_TIME_US * CLK_MHZ;
	localparam int PROG_CYC = PROG_TIME_US * CLK_MHZ;
	localparam int CNT_W = 19;
	// sequencer states
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_PROG = 3'b010,
		ST_ERASE = 3'b100
	} fwec_state_e;
endpackage
`default_nettype wire

/* File: hdl/fwec_flash_ctrl.sv */
// flash write and erase sequencer with bus registers
//
// Register access over AHB-Lite and the register offsets are this design's own decisions.
`default_nettype none
// How it works
// - two 128-byte scratchpad sectors overlay flash at local 0x00-0x7F, 0x80-0xFF
// - scratchpad reached only while scratch_select is one
// - instruction fetches never map to the scratchpad
// - sectors erase singly; erase at 0x0400 with scratch_select erases both
// - addresses above 0x07FFF take their bank from bank_select, else bank 0
// - bank_select sits in bits 5 to 4 of the bank register
// - main pages are 1024 bytes; erase sets the whole page to 0xFF
// - erase starts on a data write with all three enables set
// - user_flash_enable gates every flash write and erase
// - store_erase_enable turns qualifying writes into page erases
// - store_write_enable steers data writes to flash, else to external RAM
// - block mode off: each write programs one byte at once
// - block mode on: four-byte code blocks, two-byte scratchpad blocks
// - a block program takes the same time as a byte program
// - code blocks written 00b to 11b; programming starts after 11b
// - scratchpad block is 0b then 1b; programming starts after 1b
// - flash is read by code reads; data writes are the only program path
// - flat 0x1FC00-0x1FFFF is reserved and never written or erased
// - busy reads one during an operation; fetches stall until it ends
// - programming only clears bits; only erase sets them
// - store_write_enable holds until cleared; data reads go to external RAM
module fwec_flash_ctrl #(
	parameter int ERASE_CYCLES = fwec_pkg::ERASE_CYC
) (
	input wire logic mclk_i, // system clock
	input wire logic nrst_i, // async reset, low
	input wire logic hsel_i, // ahb select
	input wire logic [31:0] haddr_i, // ahb address
	input wire logic [1:0] htrans_i, // ahb transfer type
	input wire logic hwrite_i, // ahb write
	input wire logic [2:0] hsize_i, // ahb size
	input wire logic [31:0] hwdata_i, // ahb write data
	input wire logic hready_i, // ahb ready in
	output logic [31:0] hrdata_o, // ahb read data
	output logic hreadyout_o, // ahb ready out
	output logic hresp_o, // ahb response
	input wire logic dsw_i, // data-space write strobe
	input wire logic dsr_i, // data-space read strobe
	input wire logic [15:0] ds_addr_i, // data-space address
	input wire logic [7:0] ds_wdata_i, // data-space write byte
	output logic external_data_ram_we_o, // external ram write
	output logic external_data_ram_re_o, // external ram read
	output logic [15:0] external_data_ram_addr_o, // external ram address
	output logic [7:0] external_data_ram_wdata_o, // external ram data
	input wire logic cr_fetch_i, // code read is a fetch
	input wire logic [15:0] cr_addr_i, // code read address
	output logic [17:0] cr_addr_o, // flat code read address
	output logic stall_o, // fetch must wait
	output logic fl_prog_o, // program pulse
	output logic fl_erase_o, // erase pulse
	output logic fl_erase_both_o, // erase both scratch pages
	output logic [17:0] fl_addr_o, // flat op address
	output logic [31:0] fl_wdata_o, // program data
	output logic [3:0] fl_wmask_o, // program byte lanes
	output logic busy_o // operation running
);
	localparam int PROG_CYCLES = fwec_pkg::PROG_CYC;
	localparam logic [fwec_pkg::CNT_W-1:0] ERASE_LOAD = fwec_pkg::CNT_W'(ERASE_CYCLES - 1);
	localparam logic [fwec_pkg::CNT_W-1:0] PROG_LOAD = fwec_pkg::CNT_W'(PROG_CYCLES - 1);

	// core address to flat flash address
	function automatic logic [17:0] map_addr(input logic [15:0] a, input logic [1:0] bank,
		input logic ssel);
		logic [17:0] f;
		f = {3'h0, a[14:0]};
		if (ssel) begin
			f = fwec_pkg::SCR_BASE | {10'h0, a[7:0]};
		end else if (a[15]) begin
			f = {1'b0, bank, a[14:0]};
		end
		return f;
	endfunction

	// control registers
	logic swe_r, see_r, ssel_r, ufe_r, blk_r;
	logic [1:0] bank_r;
	logic swe_nxt, see_nxt, ssel_nxt, ufe_nxt, blk_nxt;
	logic [1:0] bank_nxt;
	logic wr_pend_r, wr_pend_nxt;
	logic [7:0] waddr_r, waddr_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic addr_ok;

	// sequencer state
	fwec_pkg::fwec_state_e state_r, state_nxt;
	logic [fwec_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
	logic [17:0] fa_r, fa_nxt;
	logic [31:0] fd_r, fd_nxt, buf_r, buf_nxt;
	logic [3:0] fm_r, fm_nxt, bm_r, bm_nxt;
	logic both_r, both_nxt;
	logic xwe_r, xre_r;
	logic [15:0] xaddr_r;
	logic [7:0] xdata_r;

	// decoded data-space write
	logic [17:0] flat;
	logic [1:0] lane;
	logic fwr, op_ok, reserved, last;

	assign addr_ok = hsel_i & hready_i & htrans_i[1];
	assign busy_o = (state_r != fwec_pkg::ST_IDLE);
	assign fl_prog_o = (state_r == fwec_pkg::ST_PROG);
	assign fl_erase_o = (state_r == fwec_pkg::ST_ERASE);
	assign fl_erase_both_o = both_r;
	assign fl_addr_o = fa_r;
	assign fl_wdata_o = fd_r;
	assign fl_wmask_o = fm_r;
	assign hrdata_o = rdata_r;
	assign hreadyout_o = 1'b1; // zero wait states, no stall path needed
	assign hresp_o = 1'b0;
	assign external_data_ram_we_o = xwe_r;
	assign external_data_ram_re_o = xre_r;
	assign external_data_ram_addr_o = xaddr_r;
	assign external_data_ram_wdata_o = xdata_r;

	// fetches ignore scratch_select so code never runs from the scratchpad
	assign cr_addr_o = map_addr(cr_addr_i, bank_r, ssel_r & ~cr_fetch_i);
	assign stall_o = cr_fetch_i & busy_o;

	// bus register file: address phase sampled, write applied in data phase
	always_comb begin
		swe_nxt = swe_r;
		see_nxt = see_r;
		ssel_nxt = ssel_r;
		ufe_nxt = ufe_r;
		blk_nxt = blk_r;
		bank_nxt = bank_r;
		wr_pend_nxt = addr_ok & hwrite_i;
		waddr_nxt = haddr_i[7:0];
		rdata_nxt = 32'h0;
		if (wr_pend_r) begin
			if (waddr_r == fwec_pkg::OFS_STORE_CTRL) begin
				swe_nxt = hwdata_i[fwec_pkg::SWE_BIT];
				see_nxt = hwdata_i[fwec_pkg::SEE_BIT];
				ssel_nxt = hwdata_i[fwec_pkg::SSEL_BIT];
			end else if (waddr_r == fwec_pkg::OFS_FLASH_SCALE) begin
				ufe_nxt = hwdata_i[fwec_pkg::UFE_BIT];
			end else if (waddr_r == fwec_pkg::OFS_BANK) begin
				bank_nxt = hwdata_i[fwec_pkg::BANK_MSB:fwec_pkg::BANK_LSB];
			end else if (waddr_r == fwec_pkg::OFS_CACHE_CTRL) begin
				blk_nxt = hwdata_i[fwec_pkg::BLK_BIT];
			end
		end
		// read data is latched at the address phase; unmapped reads give zero
		if (addr_ok & ~hwrite_i) begin
			if (haddr_i[7:0] == fwec_pkg::OFS_STORE_CTRL) begin
				rdata_nxt[fwec_pkg::SWE_BIT] = swe_r;
				rdata_nxt[fwec_pkg::SEE_BIT] = see_r;
				rdata_nxt[fwec_pkg::SSEL_BIT] = ssel_r;
			end else if (haddr_i[7:0] == fwec_pkg::OFS_FLASH_SCALE) begin
				rdata_nxt[fwec_pkg::UFE_BIT] = ufe_r;
			end else if (haddr_i[7:0] == fwec_pkg::OFS_BANK) begin
				rdata_nxt[fwec_pkg::BANK_MSB:fwec_pkg::BANK_LSB] = bank_r;
			end else if (haddr_i[7:0] == fwec_pkg::OFS_CACHE_CTRL) begin
				rdata_nxt[fwec_pkg::BLK_BIT] = blk_r;
			end else if (haddr_i[7:0] == fwec_pkg::OFS_STATUS) begin
				rdata_nxt[fwec_pkg::BUSY_BIT] = busy_o;
			end
		end
	end

	// register file flops
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			{ssel_r, see_r, swe_r} <= fwec_pkg::STORE_CTRL_RST;
			ufe_r <= 1'b0;
			blk_r <= 1'b0;
			bank_r <= fwec_pkg::BANK_RST;
			wr_pend_r <= 1'b0;
			waddr_r <= 8'h00;
			rdata_r <= 32'h0;
		end else begin
			swe_r <= swe_nxt;
			see_r <= see_nxt;
			ssel_r <= ssel_nxt;
			ufe_r <= ufe_nxt;
			blk_r <= blk_nxt;
			bank_r <= bank_nxt;
			wr_pend_r <= wr_pend_nxt;
			waddr_r <= waddr_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// decode of one data-space write
	assign flat = map_addr(ds_addr_i, bank_r, ssel_r);
	assign fwr = dsw_i & swe_r;
	assign reserved = ~ssel_r & (flat[17:10] == fwec_pkg::RSV_PAGE);
	// writes landing while busy are dropped; the core is stalled then anyway
	assign op_ok = fwr & ufe_r & ~reserved & ~busy_o;
	assign lane = ssel_r ? {1'b0, ds_addr_i[0]} : ds_addr_i[1:0];
	assign last = ssel_r ? ds_addr_i[0] : (ds_addr_i[1:0] == fwec_pkg::LAST_LANE);

	// sequencer next state
	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		fa_nxt = fa_r;
		fd_nxt = fd_r;
		fm_nxt = fm_r;
		both_nxt = both_r;
		buf_nxt = buf_r;
		bm_nxt = bm_r;
		case (state_r)
			fwec_pkg::ST_IDLE: begin
				both_nxt = 1'b0;
				if (op_ok & see_r) begin
					// erase: whole page goes to ones
					state_nxt = fwec_pkg::ST_ERASE;
					cnt_nxt = ERASE_LOAD;
					fd_nxt = {4{fwec_pkg::ERASED_BYTE}};
					fm_nxt = 4'hF;
					if (ssel_r) begin
						fa_nxt = {flat[17:fwec_pkg::SCR_PAGE_LSB], 7'h0};
						if (ds_addr_i == fwec_pkg::SCR_BOTH_ADDR) begin
							fa_nxt = fwec_pkg::SCR_BASE;
							both_nxt = 1'b1;
						end
					end else begin
						fa_nxt = {flat[17:fwec_pkg::PAGE_LSB], 10'h0};
					end
				end else if (op_ok & ~blk_r) begin
					// single byte programs straight after its write
					state_nxt = fwec_pkg::ST_PROG;
					cnt_nxt = PROG_LOAD;
					fa_nxt = flat;
					fd_nxt = {4{fwec_pkg::ERASED_BYTE}};
					fd_nxt[flat[1:0]*8 +: 8] = ds_wdata_i;
					fm_nxt = 4'h0;
					fm_nxt[flat[1:0]] = 1'b1;
				end else if (op_ok) begin
					// block: gather by lane, fire on the final address only
					buf_nxt[lane*8 +: 8] = ds_wdata_i;
					bm_nxt[lane] = 1'b1;
					if (last) begin
						state_nxt = fwec_pkg::ST_PROG;
						cnt_nxt = PROG_LOAD;
						fa_nxt = ssel_r ? {flat[17:1], 1'b0} : {flat[17:2], 2'b00};
						fm_nxt = bm_nxt;
						// lanes never written stay all ones so programming leaves them
						for (int i = 0; i < 4; i++) begin
							fd_nxt[i*8 +: 8] = bm_nxt[i] ? buf_nxt[i*8 +: 8]
								: fwec_pkg::ERASED_BYTE;
						end
						bm_nxt = 4'h0;
						buf_nxt = 32'h0;
					end
				end
			end
			fwec_pkg::ST_PROG, fwec_pkg::ST_ERASE: begin
				// busy holds until the internal count runs out
				if (cnt_r == '0) begin
					state_nxt = fwec_pkg::ST_IDLE;
				end else begin
					cnt_nxt = cnt_r - 1'b1;
				end
			end
			default: begin
				state_nxt = fwec_pkg::ST_IDLE;
			end
		endcase
	end

	// sequencer flops
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state_r <= fwec_pkg::ST_IDLE;
			cnt_r <= '0;
			fa_r <= 18'h0;
			fd_r <= 32'h0;
			fm_r <= 4'h0;
			both_r <= 1'b0;
			buf_r <= 32'h0;
			bm_r <= 4'h0;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			fa_r <= fa_nxt;
			fd_r <= fd_nxt;
			fm_r <= fm_nxt;
			both_r <= both_nxt;
			buf_r <= buf_nxt;
			bm_r <= bm_nxt;
		end
	end

	// external ram path: reads always go here, writes when flash is not chosen
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			xwe_r <= 1'b0;
			xre_r <= 1'b0;
			xaddr_r <= 16'h0;
			xdata_r <= 8'h0;
		end else begin
			xwe_r <= dsw_i & ~swe_r;
			xre_r <= dsr_i;
			xaddr_r <= ds_addr_i;
			xdata_r <= ds_wdata_i;
		end
	end

	// checks
	a_fetch_stall: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		cr_fetch_i && busy_o && cnt_r != '0 |=> !cr_fetch_i || stall_o)
		else $error("fetch not stalled during flash op");
	a_op_source: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		$rose(busy_o) |-> $past(dsw_i && swe_r && ufe_r))
		else $error("flash op without enabled data write");
	a_fetch_main: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		cr_fetch_i |-> !cr_addr_o[17])
		else $error("fetch reached scratchpad");
	a_gate_off: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		dsw_i && !ufe_r && !busy_o |=> !busy_o)
		else $error("flash op without user enable");
	a_ram_route: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		dsw_i && !swe_r |=> external_data_ram_we_o && !$rose(busy_o))
		else $error("ram write misrouted");
	a_erase_start: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		dsw_i && swe_r && see_r && ufe_r && !busy_o && !reserved |=> fl_erase_o && fl_addr_o[6:0] == 7'h0
			&& (fl_addr_o[17] || fl_addr_o[9:7] == 3'h0))
		else $error("erase did not start");
	a_bank_map: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		op_ok && !see_r && !blk_r && !ssel_r && ds_addr_i[15] |=> fl_prog_o && fl_addr_o[16:15] == $past(bank_r))
		else $error("bank not applied");
	a_prog_load: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		$rose(fl_prog_o) |-> cnt_r == PROG_LOAD ##1 fl_prog_o)
		else $error("program time wrong");
	a_pulse_end: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		$fell(busy_o) |-> $past(cnt_r) == '0)
		else $error("pulse ended early");
	a_block_wait: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		op_ok && !see_r && blk_r && !last |=> !fl_prog_o)
		else $error("block fired before last byte");
	a_scratch_addr: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		op_ok && ssel_r && !blk_r |=> fl_addr_o[17] && fl_addr_o[16:8] == 9'h0)
		else $error("scratch address wrong");
	c_byte_prog: cover property (@(posedge mclk_i) disable iff (!nrst_i) $rose(fl_prog_o) && !blk_r);
	c_block_prog: cover property (@(posedge mclk_i) disable iff (!nrst_i) $rose(fl_prog_o) && blk_r);
	c_erase: cover property (@(posedge mclk_i) disable iff (!nrst_i) $rose(fl_erase_o));
	c_erase_both: cover property (@(posedge mclk_i) disable iff (!nrst_i) $rose(fl_erase_both_o));
endmodule
`default_nettype wire

/* File: bench/fwec_core_model.sv */
// core-side model: issues data-space moves and code reads
`default_nettype none
module fwec_core_model (
	input wire logic mclk_i, // system clock
	input wire logic stall_i, // fetch must wait
	output logic dsw_o, // data-space write strobe
	output logic dsr_o, // data-space read strobe
	output logic [15:0] ds_addr_o, // data address
	output logic [7:0] ds_wdata_o, // write byte
	output logic cr_fetch_o, // code read is a fetch
	output logic [15:0] cr_addr_o // code read address
);
	timeunit 1ns;
	timeprecision 1ps;
	// quiet core at time zero
	initial begin
		dsw_o = 1'b0;
		dsr_o = 1'b0;
		ds_addr_o = 16'h0;
		ds_wdata_o = 8'h0;
		cr_fetch_o = 1'b0;
		cr_addr_o = 16'h0;
	end
	// one byte move; the only way software programs or erases
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		dsw_o <= 1'b1;
		ds_addr_o <= a;
		ds_wdata_o <= d;
		@(posedge mclk_i);
		dsw_o <= 1'b0;
		ds_wdata_o <= ~d; // stale byte must not look valid
	endtask
	// data-space read strobe for one cycle
	task automatic rd(input logic [15:0] a);
		@(posedge mclk_i);
		dsr_o <= 1'b1;
		ds_addr_o <= a;
		@(posedge mclk_i);
		dsr_o <= 1'b0;
	endtask
	// code read; a fetch holds still while the flash is busy
	task automatic fetch(input logic [15:0] a, input logic f, output int n);
		n = 0;
		@(posedge mclk_i);
		cr_fetch_o <= f;
		cr_addr_o <= a;
		do begin
			@(posedge mclk_i);
			#1;
			n++;
		end while (f && stall_i === 1'b1 && n < 5000);
	endtask
endmodule
`default_nettype wire

/* File: bench/flash_write_erase_control_bench.sv */
// self-checking bench for the flash write and erase sequencer
`default_nettype none
module flash_write_erase_control_bench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int ECYC = 50;
	localparam int ORD [3] = '{2, 0, 1};
	logic mclk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, fd;
	logic hready, hresp, dsw, dsr, cf, stall, xwe, xre, prog, ers, both, busy;
	logic [15:0] da, ca, xa;
	logic [7:0] dd, xd;
	logic [17:0] cflat, fa;
	logic [3:0] fm;
	logic [1:0] bank_m = 2'h0;
	logic ssel_m = 1'b0;
	int n_fail = 0, cmp_count = 0, cyc = 0;
	always #12.5 mclk_i = ~mclk_i;
	fwec_flash_ctrl #(.ERASE_CYCLES(ECYC)) i_dut (.mclk_i(mclk_i), .nrst_i(nrst_i), .hsel_i(hsel),
		.haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
		.hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp), .dsw_i(dsw),
		.dsr_i(dsr), .ds_addr_i(da), .ds_wdata_i(dd), .external_data_ram_we_o(xwe), .external_data_ram_re_o(xre),
		.external_data_ram_addr_o(xa), .external_data_ram_wdata_o(xd), .cr_fetch_i(cf), .cr_addr_i(ca), .cr_addr_o(cflat),
		.stall_o(stall), .fl_prog_o(prog), .fl_erase_o(ers), .fl_erase_both_o(both), .fl_addr_o(fa),
		.fl_wdata_o(fd), .fl_wmask_o(fm), .busy_o(busy));
	fwec_core_model i_core (.mclk_i(mclk_i), .stall_i(stall), .dsw_o(dsw), .dsr_o(dsr), .ds_addr_o(da),
		.ds_wdata_o(dd), .cr_fetch_o(cf), .cr_addr_o(ca));
	// hang guard, well above the longest expected run
	always @(posedge mclk_i) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			end_sim();
		end
	end
	task automatic end_sim();
		$display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t: %s got %h expected %h", $time, m, got, exp);
		end
	endtask
	// single word transfer; waits on ready at both phases, read data taken at the closing edge
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		@(posedge mclk_i);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge mclk_i); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= w ? d : 32'h0;
		do @(posedge mclk_i); while (hready !== 1'b1);
		r = hrdata;
	endtask
	// enables go last, in the safe order
	task automatic cfg(input logic [2:0] c, input logic u, input logic [1:0] b, input logic k);
		logic [31:0] r;
		ahb(1'b1, fwec_pkg::OFS_BANK, {26'h0, b, 4'h0}, r);
		ahb(1'b1, fwec_pkg::OFS_CACHE_CTRL, {31'h0, k}, r);
		ahb(1'b1, fwec_pkg::OFS_FLASH_SCALE, {31'h0, u}, r);
		ahb(1'b1, fwec_pkg::OFS_STORE_CTRL, {29'h0, c}, r);
		ssel_m = c[2];
		bank_m = b;
	endtask
	// flat address the reference map gives a data move
	function automatic logic [17:0] flat(input logic [15:0] a);
		if (ssel_m) return {10'h200, a[7:0]};
		if (a[15]) return {1'b0, bank_m, a[14:0]};
		return {2'h0, a};
	endfunction
	// accepted op: outputs describe it and busy lasts exactly the pulse
	task automatic chk_op(input logic e, input logic b, input logic [17:0] a, input logic [31:0] d,
		input logic [3:0] m, input int len);
		int n;
		n = 0;
		#1;
		chk(32'({prog, ers, both, busy}), 32'({~e, e, b, 1'b1}), "op kind");
		chk(32'(fa), 32'(a), "op address");
		chk(fd, d, "op data");
		chk(32'(fm), 32'(m), "op lanes");
		while (busy === 1'b1 && n < 500000) begin
			@(posedge mclk_i);
			#1;
			n++;
		end
		chk(32'(n), 32'(len), "op length");
	endtask
	// refused or held-back move: nothing starts, nothing reaches the RAM
	task automatic idle_chk(input string m);
		#1;
		chk(32'({busy, prog, ers, xwe}), 32'h0, m);
	endtask
	initial begin
		logic [31:0] r, w;
		logic [15:0] a;
		logic [7:0] b [4];
		logic [7:0] bq [$];
		int n;
		void'($urandom(32'h5F01));
		repeat (3) @(posedge mclk_i);
		nrst_i <= 1'b1;
		ahb(1'b1, 8'h14, 32'hFFFFFFFF, r);
		for (int i = 0; i < 6; i++) begin
			ahb(1'b0, 8'(i * 4), 32'h0, r);
			chk(r, 32'h0, "reset or unmapped value");
		end
		w = $urandom;
		ahb(1'b1, fwec_pkg::OFS_BANK, w, r);
		ahb(1'b0, fwec_pkg::OFS_BANK, 32'h0, r);
		chk(r & 32'h30, w & 32'h30, "bank field");
		$display("test registers done");
		cfg(3'h0, 1'b1, 2'h0, 1'b0);
		a = 16'($urandom);
		b[0] = 8'($urandom);
		i_core.wr(a, b[0]);
		#1;
		chk(32'({xwe, xa, xd, busy}), 32'({1'b1, a, b[0], 1'b0}), "ram write");
		cfg(3'h1, 1'b0, 2'h0, 1'b0);
		i_core.wr(a, b[0]);
		idle_chk("gated write");
		i_core.rd(a);
		#1;
		chk(32'(xre), 32'h1, "data read");
		$display("test steering done");
		cfg(3'h1, 1'b1, 2'(1 + $urandom % 3), 1'b0);
		// byte lands in the lane of its address, every other lane stays all ones
		for (int i = 0; i < 3; i++) begin
			a = (i == 0) ? 16'h7FFF : 16'($urandom) & 16'hFBFF;
			b[0] = 8'($urandom);
			w = ~(32'hFF << (8 * a[1:0])) | (32'(b[0]) << (8 * a[1:0]));
			i_core.wr(a, b[0]);
			chk_op(1'b0, 1'b0, flat(a), w, 4'h1 << a[1:0], fwec_pkg::PROG_CYC);
		end
		i_core.fetch(16'hC123, 1'b1, n);
		chk(32'(cflat), 32'(flat(16'hC123)), "banked fetch");
		i_core.wr(16'h0100, 8'h00);
		ahb(1'b0, fwec_pkg::OFS_STATUS, 32'h0, r);
		chk(r, 32'h1, "busy status");
		chk(32'({hresp, hready}), 32'h1, "status answer");
		i_core.fetch(16'h0010, 1'b1, n);
		chk(32'({n > 100, stall, busy}), 32'h4, "fetch stall");
		$display("test byte program done");
		cfg(3'h4, 1'b0, 2'h0, 1'b0);
		i_core.fetch(16'h0033, 1'b0, n);
		chk(32'(cflat), 32'h20033, "scratch code read");
		i_core.fetch(16'h0033, 1'b1, n);
		chk(32'(cflat), 32'h00033, "fetch map");
		cfg(3'h3, 1'b1, 2'(1 + $urandom % 3), 1'b0);
		a = 16'h8000 | (16'($urandom) & 16'h3FFF);
		i_core.wr(a, 8'h55);
		chk_op(1'b1, 1'b0, flat(a) & 18'h3FC00, 32'hFFFFFFFF, 4'hF, ECYC);
		cfg(3'h7, 1'b1, 2'h0, 1'b0);
		i_core.wr(16'h0085, 8'h00);
		chk_op(1'b1, 1'b0, 18'h20080, 32'hFFFFFFFF, 4'hF, ECYC);
		i_core.wr(fwec_pkg::SCR_BOTH_ADDR, 8'h00);
		chk_op(1'b1, 1'b1, 18'h20000, 32'hFFFFFFFF, 4'hF, ECYC);
		cfg(3'h3, 1'b1, 2'h3, 1'b0);
		i_core.wr(16'hFC40, 8'h00);
		idle_chk("reserved page");
		ahb(1'b0, fwec_pkg::OFS_STORE_CTRL, 32'h0, r);
		chk(r, 32'h3, "write enable held");
		$display("test erase done");
		cfg(3'h1, 1'b1, 2'h0, 1'b1);
		a = 16'($urandom) & 16'h7FFC;
		for (int i = 0; i < 4; i++) b[i] = 8'($urandom);
		for (int i = 0; i < 3; i++) begin
			i_core.wr(a | 16'(ORD[i]), b[ORD[i]]);
			idle_chk("block lane");
		end
		i_core.wr(a | 16'h3, b[3]);
		chk_op(1'b0, 1'b0, 18'(a), {b[3], b[2], b[1], b[0]}, 4'hF, fwec_pkg::PROG_CYC);
		// in-order banked block; lane 1 is left alone by writing ones into it
		cfg(3'h1, 1'b1, 2'h1, 1'b1); // bank 01 is valid on either flash size
		a = 16'h8000 | (16'($urandom) & 16'h3FFC);
		for (int i = 0; i < 4; i++) begin
			bq.push_back((i == 1) ? 8'hFF : 8'($urandom));
			i_core.wr(a | 16'(i), bq[i]);
			if (i < 3) idle_chk("ordered lane");
		end
		chk_op(1'b0, 1'b0, flat(a), {bq[3], bq[2], bq[1], bq[0]}, 4'hF, fwec_pkg::PROG_CYC);
		cfg(3'h5, 1'b1, 2'h0, 1'b1);
		i_core.wr(16'h0010, b[0]);
		idle_chk("scratch lane");
		i_core.wr(16'h0011, b[1]);
		chk_op(1'b0, 1'b0, 18'h20010, {16'hFFFF, b[1], b[0]}, 4'h3, fwec_pkg::PROG_CYC);
		$display("test block program done");
		end_sim();
	end
endmodule
`default_nettype wire
